//--- cfgip_uart.sv
// Package of constants for the configuration instruction parser, and the
// byte-wide serial transceiver that it instantiates.
// Assumes one 125 MHz clock and a synchronous active-high reset.

`timescale 1ns/1ps

// ============================================================
// Shared constants
package cfgip_pkg;
    localparam int unsigned CLK_HZ      = 125000000;
    localparam int unsigned BAUD_RATE   = 115200;
    localparam logic [10:0] BIT_CYC     = 11'(CLK_HZ / BAUD_RATE);
    localparam logic [10:0] HALF_CYC    = 11'(CLK_HZ / BAUD_RATE / 2);
    localparam logic [3:0]  LAST_BIT    = 4'h9;
    localparam logic [3:0]  DATA_LAST   = 4'h8;

    localparam logic [7:0]  HDR0        = 8'h42;
    localparam logic [7:0]  HDR1        = 8'h57;
    localparam logic [7:0]  TYPE_BYTE   = 8'h02;
    localparam logic [7:0]  STATUS_TX   = 8'h00;
    localparam logic [7:0]  ST_OK       = 8'h01;
    localparam logic [7:0]  ST_BAD_CMD  = 8'hff;
    localparam logic [7:0]  ST_BAD_PAR  = 8'h0f;

    localparam logic [2:0]  POS_STATUS  = 3'h3;
    localparam logic [2:0]  POS_LOW     = 3'h4;
    localparam logic [2:0]  POS_HIGH    = 3'h5;
    localparam logic [2:0]  POS_SINGLE  = 3'h6;
    localparam logic [2:0]  POS_CODE    = 3'h7;
    localparam logic [2:0]  BODY_LAST   = 3'h7;

    localparam logic [7:0]  CMD_CFG     = 8'h02;
    localparam logic [7:0]  CMD_FORMAT  = 8'h06;
    localparam logic [7:0]  CMD_CYCLE   = 8'h07;
    localparam logic [7:0]  CMD_MODE    = 8'h11;
    localparam logic [7:0]  CMD_PATTERN = 8'h14;
    localparam logic [7:0]  CMD_LIMIT   = 8'h19;
    localparam logic [7:0]  CMD_UNIT    = 8'h1a;
    localparam logic [7:0]  CMD_STR_LO  = 8'h20;
    localparam logic [7:0]  CMD_STR_HI  = 8'h21;

    localparam logic [15:0] CYCLE_STEP  = 16'h000a;
    localparam logic [15:0] CYCLE_RST   = 16'h000a;
    localparam logic [7:0]  UNIT_MM_VAL = 8'h00;
    localparam logic [7:0]  UNIT_CM_VAL = 8'h01;
    localparam logic [7:0]  FMT_STD     = 8'h01;
    localparam logic [7:0]  FMT_TEXT    = 8'h04;
    localparam logic [7:0]  MODE_SHORT  = 8'h02;
    localparam logic [7:0]  MODE_LONG   = 8'h07;
endpackage

// ============================================================
// Serial transceiver, 8 data bits, 1 stop bit, no parity
module cfgip_uart (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       rxd,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_data,
    output logic            tx_busy,
    output logic            txd
);
    import cfgip_pkg::*;

    logic        s1_reg,  s2_reg;
    logic        rb_reg,  rb_next;
    logic [10:0] rc_reg,  rc_next;
    logic [3:0]  rn_reg,  rn_next;
    logic [7:0]  rs_reg,  rs_next;
    logic        rv_reg,  rv_next;
    logic [7:0]  rd_reg,  rd_next;
    logic        tb_reg,  tb_next;
    logic [10:0] tc_reg,  tc_next;
    logic [3:0]  tn_reg,  tn_next;
    logic [8:0]  ts_reg,  ts_next;
    logic        tx_reg,  tx_next;

    // ============================================================
    // Receiver: the line is synchronised, then sampled mid-bit.
    always_comb begin
        rb_next = rb_reg;
        rc_next = rc_reg;
        rn_next = rn_reg;
        rs_next = rs_reg;
        rv_next = 1'b0;
        rd_next = rd_reg;
        if (!rb_reg) begin
            if (!s2_reg) begin
                rb_next = 1'b1;
                rc_next = HALF_CYC;
                rn_next = 4'h0;
            end
        end else if (rc_reg != 11'h000) begin
            rc_next = rc_reg - 11'h001;
        end else begin
            rc_next = BIT_CYC - 11'h001;
            if (rn_reg == 4'h0) begin
                // A start bit that has gone high again was a glitch.
                if (s2_reg) begin
                    rb_next = 1'b0;
                end else begin
                    rn_next = 4'h1;
                end
            end else if (rn_reg <= DATA_LAST) begin
                rs_next = {s2_reg, rs_reg[7:1]};
                rn_next = rn_reg + 4'h1;
            end else begin
                rb_next = 1'b0;
                rv_next = s2_reg;
                if (s2_reg) begin
                    rd_next = rs_reg;
                end
            end
        end
    end

    // ============================================================
    // Transmitter
    always_comb begin
        tb_next = tb_reg;
        tc_next = tc_reg;
        tn_next = tn_reg;
        ts_next = ts_reg;
        tx_next = tx_reg;
        if (!tb_reg) begin
            tx_next = 1'b1;
            if (tx_start) begin
                tb_next = 1'b1;
                tc_next = BIT_CYC - 11'h001;
                tn_next = 4'h0;
                ts_next = {1'b1, tx_data};
                tx_next = 1'b0;
            end
        end else if (tc_reg != 11'h000) begin
            tc_next = tc_reg - 11'h001;
        end else if (tn_reg == LAST_BIT) begin
            tb_next = 1'b0;
        end else begin
            tc_next = BIT_CYC - 11'h001;
            tn_next = tn_reg + 4'h1;
            tx_next = ts_reg[0];
            ts_next = {1'b1, ts_reg[8:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            rb_reg <= 1'b0;
            rc_reg <= 11'h000;
            rn_reg <= 4'h0;
            rs_reg <= 8'h00;
            rv_reg <= 1'b0;
            rd_reg <= 8'h00;
            tb_reg <= 1'b0;
            tc_reg <= 11'h000;
            tn_reg <= 4'h0;
            ts_reg <= 9'h1ff;
            tx_reg <= 1'b1;
        end else begin
            s1_reg <= rxd;
            s2_reg <= s1_reg;
            rb_reg <= rb_next;
            rc_reg <= rc_next;
            rn_reg <= rn_next;
            rs_reg <= rs_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            tb_reg <= tb_next;
            tc_reg <= tc_next;
            tn_reg <= tn_next;
            ts_reg <= ts_next;
            tx_reg <= tx_next;
        end
    end

    assign rx_valid = rv_reg;
    assign rx_data  = rd_reg;
    assign tx_busy  = tb_reg;
    assign txd      = tx_reg;
endmodule

//--- cfgip_parser.sv
// Configuration instruction parser: takes eight-byte instruction frames from
// the serial line, checks and applies them, and answers with an echo frame.
// Assumes cfgip_uart.sv (package and transceiver) is compiled first, and that
// an external non-volatile store takes each write pulse on the NV_* ports.

`timescale 1ns/1ps

module cfgip_parser (
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    input  wire logic        RXD,
    output logic             TXD,
    input  wire logic [15:0] DIST_IN,
    output logic      [15:0] DIST_OUT,
    output logic             CFG_MODE,
    output logic             UNIT_MM,
    output logic      [15:0] OUT_CYCLE,
    output logic             NV_WR,
    output logic      [7:0]  NV_CODE,
    output logic      [23:0] NV_PARAM
);
    import cfgip_pkg::*;

    typedef enum logic [4:0] {
        S_HDR0 = 5'b00001,
        S_HDR1 = 5'b00010,
        S_BODY = 5'b00100,
        S_EVAL = 5'b01000,
        S_SEND = 5'b10000
    } cfgip_state_t;

    cfgip_state_t st_reg, st_next;
    logic [7:0]   frm_reg [8];
    logic [7:0]   frm_next [8];
    logic [2:0]   idx_reg, idx_next;
    logic         go_reg,  go_next;
    logic         cfg_reg, cfg_next;
    logic         mm_reg,  mm_next;
    logic [15:0]  cyc_reg, cyc_next;
    logic         nvw_reg, nvw_next;
    logic [7:0]   nvc_reg, nvc_next;
    logic [23:0]  nvp_reg, nvp_next;
    logic [15:0]  dst_reg, dst_next;
    logic         rx_valid;
    logic [7:0]   rx_data;
    logic         tx_busy;
    logic [7:0]   status;
    logic [15:0]  param16;
    logic [7:0]   single;
    logic [7:0]   code;

    // ============================================================
    // Serial link
    cfgip_uart u_uart (
        .clk      (MCLK),
        .rst      (SYS_RST),
        .rxd      (RXD),
        .rx_valid (rx_valid),
        .rx_data  (rx_data),
        .tx_start (go_reg),
        .tx_data  (frm_reg[idx_reg]),
        .tx_busy  (tx_busy),
        .txd      (TXD)
    );

    function automatic logic is_pair(input logic [7:0] v,
                                     input logic [7:0] a,
                                     input logic [7:0] b);
        return (v == a) || (v == b);
    endfunction

    // ============================================================
    // Instruction evaluation
    always_comb begin
        param16 = {frm_reg[POS_HIGH], frm_reg[POS_LOW]};
        single  = frm_reg[POS_SINGLE];
        code    = frm_reg[POS_CODE];
        status  = ST_OK;
        // A frame of another type is not an instruction this block knows.
        if (frm_reg[2] != TYPE_BYTE) begin
            status = ST_BAD_CMD;
        end else if (!cfg_reg && code != CMD_CFG) begin
            status = ST_BAD_CMD;
        end else if (frm_reg[POS_STATUS] != STATUS_TX) begin
            status = ST_BAD_PAR;
        end else begin
            unique case (code)
                CMD_CFG: begin
                    if (single > 8'h01) begin
                        status = ST_BAD_PAR;
                    end
                end
                CMD_FORMAT: begin
                    if (!is_pair(single, FMT_STD, FMT_TEXT)) begin
                        status = ST_BAD_PAR;
                    end
                end
                CMD_CYCLE: begin
                    if (param16 == 16'h0000 ||
                        (param16 % CYCLE_STEP) != 16'h0000) begin
                        status = ST_BAD_PAR;
                    end
                end
                CMD_MODE: begin
                    if (!is_pair(single, MODE_SHORT, MODE_LONG)) begin
                        status = ST_BAD_PAR;
                    end
                end
                CMD_PATTERN, CMD_LIMIT: begin
                    if (single > 8'h01) begin
                        status = ST_BAD_PAR;
                    end
                end
                CMD_UNIT: begin
                    if (!is_pair(single, UNIT_MM_VAL, UNIT_CM_VAL)) begin
                        status = ST_BAD_PAR;
                    end
                end
                CMD_STR_LO, CMD_STR_HI: begin
                end
                default: begin
                    status = ST_BAD_CMD;
                end
            endcase
        end
    end

    // ============================================================
    // Frame sequencing
    always_comb begin
        st_next  = st_reg;
        frm_next = frm_reg;
        idx_next = idx_reg;
        go_next  = 1'b0;
        cfg_next = cfg_reg;
        mm_next  = mm_reg;
        cyc_next = cyc_reg;
        nvw_next = 1'b0;
        nvc_next = nvc_reg;
        nvp_next = nvp_reg;
        unique case (st_reg)
            S_HDR0: begin
                if (rx_valid && rx_data == HDR0) begin
                    frm_next[0] = rx_data;
                    st_next     = S_HDR1;
                end
            end
            S_HDR1: begin
                if (rx_valid) begin
                    if (rx_data == HDR1) begin
                        frm_next[1] = rx_data;
                        idx_next    = 3'h2;
                        st_next     = S_BODY;
                    end else if (rx_data != HDR0) begin
                        st_next = S_HDR0;
                    end
                end
            end
            S_BODY: begin
                if (rx_valid) begin
                    frm_next[idx_reg] = rx_data;
                    idx_next          = idx_reg + 3'h1;
                    if (idx_reg == BODY_LAST) begin
                        st_next = S_EVAL;
                    end
                end
            end
            S_EVAL: begin
                // Settings change only on success, so a bad frame
                // leaves both the live state and the store untouched.
                if (status == ST_OK) begin
                    if (code == CMD_CFG) begin
                        cfg_next = single[0];
                    end else begin
                        nvw_next = 1'b1;
                        nvc_next = code;
                        nvp_next = {single, param16};
                        if (code == CMD_UNIT) begin
                            mm_next = (single == UNIT_MM_VAL);
                        end
                        if (code == CMD_CYCLE) begin
                            cyc_next = param16;
                        end
                    end
                end
                frm_next[POS_STATUS] = status;
                idx_next             = 3'h0;
                go_next              = 1'b1;
                st_next              = S_SEND;
            end
            S_SEND: begin
                // Bytes that arrive while the echo goes out are dropped.
                if (!tx_busy && !go_reg) begin
                    if (idx_reg == BODY_LAST) begin
                        st_next = S_HDR0;
                    end else begin
                        idx_next = idx_reg + 3'h1;
                        go_next  = 1'b1;
                    end
                end
            end
        endcase
    end

    // ============================================================
    // Distance scaling
    always_comb begin
        dst_next = mm_reg ? 16'((DIST_IN << 3) + (DIST_IN << 1))
                          : DIST_IN;
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            st_reg  <= S_HDR0;
            frm_reg <= '{default: 8'h00};
            idx_reg <= 3'h0;
            go_reg  <= 1'b0;
            cfg_reg <= 1'b0;
            mm_reg  <= 1'b0;
            cyc_reg <= CYCLE_RST;
            nvw_reg <= 1'b0;
            nvc_reg <= 8'h00;
            nvp_reg <= 24'h000000;
            dst_reg <= 16'h0000;
        end else begin
            st_reg  <= st_next;
            frm_reg <= frm_next;
            idx_reg <= idx_next;
            go_reg  <= go_next;
            cfg_reg <= cfg_next;
            mm_reg  <= mm_next;
            cyc_reg <= cyc_next;
            nvw_reg <= nvw_next;
            nvc_reg <= nvc_next;
            nvp_reg <= nvp_next;
            dst_reg <= dst_next;
        end
    end

    assign DIST_OUT  = dst_reg;
    assign CFG_MODE  = cfg_reg;
    assign UNIT_MM   = mm_reg;
    assign OUT_CYCLE = cyc_reg;
    assign NV_WR     = nvw_reg;
    assign NV_CODE   = nvc_reg;
    assign NV_PARAM  = nvp_reg;
endmodule

//--- cfgip_parser_chk.sv
// Checker for the configuration instruction parser, bound to its top ports.
// Assumes cfgip_pkg is compiled first and one clock domain, MCLK.

`timescale 1ns/1ps

module cfgip_parser_chk
    import cfgip_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        SYS_RST,
    input wire logic        RXD,
    input wire logic        TXD,
    input wire logic [15:0] DIST_IN,
    input wire logic [15:0] DIST_OUT,
    input wire logic        CFG_MODE,
    input wire logic        UNIT_MM,
    input wire logic [15:0] OUT_CYCLE,
    input wire logic        NV_WR,
    input wire logic [7:0]  NV_CODE,
    input wire logic [23:0] NV_PARAM
);
    // ========
    // Run length of the echo line, saturating so idle never wraps.
    logic [10:0] run_len_reg;
    logic [10:0] run_len_next;
    logic        txd_prev_reg;

    always_comb begin
        run_len_next = run_len_reg + {10'h000, run_len_reg != 11'h7ff};
        if (SYS_RST || TXD != txd_prev_reg) begin
            run_len_next = SYS_RST ? 11'h7ff : 11'h001;
        end
    end

    always_ff @(posedge MCLK) begin
        run_len_reg  <= run_len_next;
        txd_prev_reg <= TXD;
    end

    // ========
    // Properties.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence s_unit_write;
        NV_WR && NV_CODE == CMD_UNIT;
    endsequence

    sequence s_cycle_write;
        NV_WR && NV_CODE == CMD_CYCLE;
    endsequence

    a_reset_vals: assert property ($fell(SYS_RST) |-> TXD && !CFG_MODE
        && !UNIT_MM && !NV_WR && OUT_CYCLE == CYCLE_RST)
        else $error("Outputs not at reset values after reset");
    a_nv_pulse: assert property (NV_WR |=> !NV_WR)
        else $error("Store write longer than one cycle");
    a_nv_in_cfg: assert property (NV_WR |-> CFG_MODE && NV_CODE != CMD_CFG)
        else $error("Store write outside configuration mode");
    a_nv_cause: assert property ((!$past(SYS_RST) && ($changed(NV_CODE)
        || $changed(NV_PARAM))) |-> NV_WR)
        else $error("Store code or parameter changed without a write");
    a_unit_follow: assert property (s_unit_write |-> ##[0:1]
        UNIT_MM == (NV_PARAM[23:16] == UNIT_MM_VAL))
        else $error("Unit flag does not follow unit write");
    a_cycle_follow: assert property (s_cycle_write |-> ##[0:1]
        OUT_CYCLE == NV_PARAM[15:0])
        else $error("Output cycle does not follow cycle write");
    a_cycle_legal: assert property (OUT_CYCLE != 16'h0000
        && OUT_CYCLE % CYCLE_STEP == 16'h0000)
        else $error("Output cycle holds an illegal value");
    a_dist_scale: assert property (!$past(SYS_RST) |-> DIST_OUT ==
        ($past(UNIT_MM) ? 16'($past(DIST_IN) * 16'h000a) : $past(DIST_IN)))
        else $error("Distance output scaled wrongly");
    a_tx_bit_len: assert property ($changed(TXD) |->
        run_len_reg >= BIT_CYC - 11'h003)
        else $error("Echo line bit shorter than one bit period");
endmodule

bind cfgip_parser cfgip_parser_chk u_chk (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .RXD(RXD), .TXD(TXD),
    .DIST_IN(DIST_IN), .DIST_OUT(DIST_OUT), .CFG_MODE(CFG_MODE),
    .UNIT_MM(UNIT_MM), .OUT_CYCLE(OUT_CYCLE), .NV_WR(NV_WR),
    .NV_CODE(NV_CODE), .NV_PARAM(NV_PARAM)
);

//--- cfgip_host.sv
// Host model: sends instruction bytes on the serial line, reads the echo.
// Assumes cfgip_pkg is compiled first; tasks are called at a clock edge.

`timescale 1ns/1ps

module cfgip_host
    import cfgip_pkg::*;
(
    input  wire logic clk,
    output logic      rxd,
    input  wire logic txd
);
    // ========
    // The line idles high, as a pulled-up serial line does.
    initial rxd = 1'b1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] bits;
        bits = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= bits[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask

    task automatic send_frame(input logic [63:0] f);
        for (int i = 7; i >= 0; i--) begin
            send_byte(f[8*i +: 8]);
        end
    endtask

    // Waits are bounded so a silent device cannot hang the reader.
    task automatic recv_frame(output logic [63:0] f, output logic ok);
        logic [7:0] b;
        int         n;
        f  = 64'h0;
        ok = 1'b1;
        for (int k = 0; k < 8; k++) begin
            n = 0;
            while (txd !== 1'b0 && n < 150000) begin
                @(posedge clk);
                n++;
            end
            if (n >= 150000) begin
                ok = 1'b0;
                return;
            end
            repeat (HALF_CYC) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                b[i] = txd;
            end
            repeat (BIT_CYC) @(posedge clk);
            if (txd !== 1'b1) ok = 1'b0;
            f = {f[55:0], b};
        end
    endtask
endmodule

//--- testbench.sv
// Testbench for the configuration instruction parser.
// Assumes the design, the host model and the checker are compiled first.

`timescale 1ns/1ps

module testbench;
    import cfgip_pkg::*;
    logic        mclk;
    logic        sys_rst;
    logic        rxd;
    logic        txd;
    logic [15:0] dist_in;
    logic [15:0] dist_out;
    logic        cfg_mode;
    logic        unit_mm;
    logic [15:0] out_cycle;
    logic        nv_wr;
    logic [7:0]  nv_code;
    logic [23:0] nv_param;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n_nv = 0;

    cfgip_parser dut (
        .MCLK(mclk), .SYS_RST(sys_rst), .RXD(rxd), .TXD(txd),
        .DIST_IN(dist_in), .DIST_OUT(dist_out), .CFG_MODE(cfg_mode),
        .UNIT_MM(unit_mm), .OUT_CYCLE(out_cycle), .NV_WR(nv_wr),
        .NV_CODE(nv_code), .NV_PARAM(nv_param)
    );

    cfgip_host host (.clk(mclk), .rxd(rxd), .txd(txd));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) if (nv_wr === 1'b1) n_nv <= n_nv + 1;

    // ========
    // Shared tasks.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One instruction and its echo; the reply is read while bytes go out.
    task automatic transact(input logic [63:0] f, input logic [7:0] st,
                            input logic garb);
        logic [63:0] e;
        logic        ok;
        fork
            begin
                if (garb) begin
                    host.send_byte(8'h42);
                    host.send_byte(8'h13);
                    host.send_byte(8'h55);
                end
                host.send_frame(f);
            end
            host.recv_frame(e, ok);
        join
        check({63'h0, ok}, 64'h1);
        check(e, {f[63:40], st, f[31:0]});
        repeat (BIT_CYC) @(posedge mclk);
    endtask

    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ========
    // Scenarios.
    task automatic t_outside();
        transact(64'h425702000000001a, ST_BAD_CMD, 1'b0);
        check(unit_mm, 64'h0);
        check(n_nv, 64'h0);
    endtask

    task automatic t_enter();
        transact(64'h4257020000000102, ST_OK, 1'b0);
        check(cfg_mode, 64'h1);
    endtask

    task automatic t_unit();
        transact(64'h425702000000001a, ST_OK, 1'b1);
        check(unit_mm, 64'h1);
        check(nv_code, 64'h1a);
        check(n_nv, 64'h1);
        dist_in <= 16'h1a2b;
        repeat (3) @(posedge mclk);
        check(dist_out, 64'h05ae);
    endtask

    task automatic t_cycle();
        transact(64'h425702002c010007, ST_OK, 1'b0);
        check(out_cycle, 64'h012c);
        check(nv_param, 64'h00012c);
        check(n_nv, 64'h2);
    endtask

    task automatic t_refuse();
        transact(64'h4257020015000007, ST_BAD_PAR, 1'b0);
        transact(64'h4257020000000033, ST_BAD_CMD, 1'b0);
        transact(64'h4257010000000006, ST_BAD_CMD, 1'b0);
        transact(64'h4257020500000106, ST_BAD_PAR, 1'b0);
        check(out_cycle, 64'h012c);
        check(n_nv, 64'h2);
    endtask

    task automatic t_exit();
        transact(64'h4257020000000002, ST_OK, 1'b0);
        check(cfg_mode, 64'h0);
        check(n_nv, 64'h2);
    endtask

    // Settings are not reloaded from the store, so reset clears the flags and loads CYCLE_RST.
    task automatic t_reset();
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check(unit_mm, 64'h0);
        check(out_cycle, {48'h0, CYCLE_RST});
        check(nv_code, 64'h0);
        check(dist_out, 64'h1a2b);
    endtask

    // ========
    // Main sequence and watchdog; nine frames take about 1.6M cycles.
    initial begin
        sys_rst = 1'b1;
        dist_in = 16'h0000;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_outside();
        t_enter();
        t_unit();
        t_cycle();
        t_refuse();
        t_exit();
        t_reset();
        wrap_up();
    end

    initial begin
        repeat (2000000) @(posedge mclk);
        n_mismatch++;
        wrap_up();
    end
endmodule
